// ===== pkg/bert_pkg.sv
/*
 Shared constants for the bit error rate tester: register word indices,
 control and status field positions, pattern kinds and checker timing.
 Assumes a 32-bit Avalon-MM slave where register index N sits at byte N*4.
*/
package bert_pkg;
	////////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_PATTERN0 = 16'h1101;
	localparam logic [15:0] IDX_PATTERN3 = 16'h1104;
	localparam logic [15:0] IDX_CTRL1 = 16'h1105;
	localparam logic [15:0] IDX_CTRL2 = 16'h1106;
	localparam logic [15:0] IDX_BITCNT0 = 16'h1107;
	localparam logic [15:0] IDX_BITCNT1 = 16'h1108;
	localparam logic [15:0] IDX_BITCNT2 = 16'h1109;
	localparam logic [15:0] IDX_BITCNT3 = 16'h110A;
	localparam logic [15:0] IDX_ERRCNT0 = 16'h110B;
	localparam logic [15:0] IDX_ERRCNT1 = 16'h110C;
	localparam logic [15:0] IDX_ERRCNT2 = 16'h110D;
	localparam logic [15:0] IDX_STATUS = 16'h110E;
	localparam logic [15:0] IDX_MASK = 16'h110F;
	localparam logic [7:0] REG_RESET = 8'h00;
	////////////////////////////////////////////////////////////////////////////
	localparam int C1_REALIGN = 0;
	localparam int C1_LATCH = 1;
	localparam int C1_KIND_LSB = 2;
	localparam int C1_RX_INV = 5;
	localparam int C1_TX_INV = 6;
	localparam int C1_LOAD = 7;
	localparam int C2_LEN_LSB = 0;
	localparam int C2_SINGLE = 4;
	localparam int C2_RATE_LSB = 5;
	////////////////////////////////////////////////////////////////////////////
	localparam int ST_LOCKED = 0;
	localparam int ST_LOST = 1;
	localparam int ST_ZEROS = 2;
	localparam int ST_ONES = 3;
	localparam int ST_ERR_OVF = 4;
	localparam int ST_BIT_OVF = 5;
	localparam int ST_BIT_ERR = 6;
	localparam int ST_W = 7;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [5:0] LOCK_MATCH_LAST = 6'h1F;
	localparam logic [5:0] RUN_FULL = 6'h20;
	localparam logic [5:0] REPEAT_BASE = 6'h11;
	localparam logic [5:0] LOSS_WINDOW_LAST = 6'h3F;
	localparam logic [2:0] LOSS_ERRORS = 3'h6;
	localparam logic [31:0] TX_SEED_RESET = 32'hFFFFFFFF;
	localparam logic [31:0] RX_SEED_RESET = 32'h00000000;
	localparam logic [23:0] DECADE [8] = '{24'h000001, 24'h00000A, 24'h000064, 24'h0003E8,
		24'h002710, 24'h0186A0, 24'h0F4240, 24'h989680};
	typedef enum logic [2:0] {
		KIND_PRBS7 = 3'b000,
		KIND_PRBS11 = 3'b001,
		KIND_PRBS15 = 3'b010,
		KIND_QRSS = 3'b011,
		KIND_REPEAT = 3'b100,
		KIND_ALT_WORD = 3'b101,
		KIND_DALY = 3'b110,
		KIND_PRBS9 = 3'b111
	} kind_type;
	typedef enum logic [0:0] {
		CHK_SEARCH = 1'b0,
		CHK_LOCKED = 1'b1
	} chk_state_type;
endpackage

// ===== src/bert_pattern_engine.sv
/*
 Pattern history register shared by generator and checker: predicts the next
 bit from the last 32 bits, either by LFSR taps or by a repeat distance.
 Assumes i_step is a one-cycle bit strobe on the same clock.
*/
module bert_pattern_engine #(
	parameter logic [31:0] RESET_HISTORY = 32'h00000000
) (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_step,
	input wire bert_pkg::kind_type i_kind,
	input wire logic [3:0] i_len_code,
	input wire logic i_seed_load,
	input wire logic [31:0] i_seed,
	input wire logic i_follow,
	input wire logic i_in_bit,
	output logic o_expected
);
	import bert_pkg::*;

	logic [31:0] history_q;
	logic [5:0] rep_len;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		rep_len = REPEAT_BASE + {2'h0, i_len_code};
		case (i_kind)
			KIND_PRBS7: o_expected = history_q[6] ^ history_q[5];
			KIND_PRBS11: o_expected = history_q[10] ^ history_q[8];
			KIND_PRBS15: o_expected = history_q[14] ^ history_q[13];
			KIND_QRSS: o_expected = history_q[19] ^ history_q[16];
			KIND_PRBS9: o_expected = history_q[8] ^ history_q[4];
			// length code matters only here, the taps above ignore it
			default: o_expected = history_q[5'(rep_len - 6'h01)];
		endcase
	end

	// while following, the received bit refills the history (self-synchronising)
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			history_q <= RESET_HISTORY;
		end else if (i_seed_load) begin
			history_q <= i_seed;
		end else if (i_step) begin
			history_q <= {history_q[30:0], i_follow ? i_in_bit : o_expected};
		end
	end
endmodule

// ===== src/bert_error_inject.sv
/*
 Error insertion timer: one error per decade count of generated bits, plus
 a single error armed by a one-cycle request.
 Assumes i_step is a one-cycle bit strobe on the same clock.
*/
module bert_error_inject (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_step,
	input wire logic [2:0] i_rate,
	input wire logic i_single_req,
	output logic o_inject
);
	import bert_pkg::*;

	logic [23:0] count_q;
	logic pending_q;
	logic rate_hit;

	assign rate_hit = (i_rate != 3'h0) && (count_q >= DECADE[i_rate] - 24'h000001);
	assign o_inject = i_step && (rate_hit || pending_q);

	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count_q <= 24'h000000;
		end else if (i_rate == 3'h0) begin
			count_q <= 24'h000000;
		end else if (i_step) begin
			count_q <= rate_hit ? 24'h000000 : count_q + 24'h000001;
		end
	end

	// a single request waits for the next bit; a new request meanwhile merges
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pending_q <= 1'b0;
		end else if (i_single_req) begin
			pending_q <= 1'b1;
		end else if (i_step) begin
			pending_q <= 1'b0;
		end
	end
endmodule

// ===== src/bert_tester.sv
/*
 Bit error rate tester for one channel: transmit pattern generator with
 error insertion, receive checker with lock search, bit and error counters,
 latched status with mask and interrupt, Avalon-MM register slave.
 Assumes the framer gives one-cycle bit strobes on I_CLOCK for each side,
 and a master that holds its request until waitrequest is seen low.
*/
// Functional notes
// - realign bit rising edge restarts pattern search
// - rate field inserts errors one per decade
// - single-inject rising edge corrupts exactly one bit
// - repeat length is seventeen plus code
// - length code ignored for pseudorandom patterns
// - bit count in four bytes, LSB first
// - error count in three bytes, LSB first
// - all status bits latch and can interrupt
// - bit errors detected only while locked
// - bit counter wrap sets overflow event
// - error counter wrap sets overflow event
// - thirty-two consecutive ones set all-ones
// - thirty-two consecutive zeros set all-zeros
// - entering search sets lock-lost
// - lock after thirty-two consecutive matching bits
// - per-event mask, one enables interrupt
// - conditions interrupt on set and clear
// - latch strobe copies counts, clears counters
// - kind field picks generator and checker pattern
// - separate transmit and receive inversion bits
module bert_tester #(
	parameter int BIT_CNT_W = 32,
	parameter int ERR_CNT_W = 24
) (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic [bert_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_TX_BIT_STROBE,
	output logic O_TX_DATA,
	input wire logic I_RX_BIT_STROBE,
	input wire logic I_RX_DATA,
	output logic O_IRQ
);
	import bert_pkg::*;

	logic waitreq_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [15:0] idx;
	logic wr_acc;
	logic rd_acc;
	logic wr_lane0;
	logic [31:0] pattern_q;
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [7:0] ctrl1_prev_q;
	logic [7:0] ctrl2_prev_q;
	logic [ST_W-1:0] mask_q;
	logic [ST_W-1:0] status_q;
	logic [ST_W-1:0] status_set;
	logic [ST_W-1:0] status_clr;
	logic realign_rise;
	logic latch_rise;
	logic load_rise;
	logic single_rise;
	kind_type kind;
	logic tx_expected;
	logic tx_inject;
	logic tx_q;
	logic rx_bit;
	logic rx_expected;
	logic mismatch;
	chk_state_type chk_q;
	logic [5:0] match_cnt_q;
	logic [5:0] window_q;
	logic [2:0] window_err_q;
	logic err_pulse;
	logic [5:0] ones_run_q;
	logic [5:0] zeros_run_q;
	logic ones_live;
	logic zeros_live;
	logic [3:0] cond_prev_q;
	logic [3:0] cond_live;
	logic [BIT_CNT_W-1:0] bit_counter_q;
	logic [ERR_CNT_W-1:0] error_counter_q;
	logic [BIT_CNT_W-1:0] bit_hold_q;
	logic [ERR_CNT_W-1:0] err_hold_q;
	logic bit_inc;
	logic irq_q;

	////////////////////////////////////////////////////////////////////////////
	// bus slave: one wait cycle, then waitrequest low for exactly one cycle
	assign idx = I_AVS_ADDRESS[ADDR_W-1:2];
	assign wr_acc = I_AVS_WRITE && !waitreq_q;
	assign rd_acc = I_AVS_READ && !waitreq_q;
	assign wr_lane0 = wr_acc && I_AVS_BYTEENABLE[0];

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			waitreq_q <= 1'b1;
		end else begin
			waitreq_q <= !((I_AVS_READ || I_AVS_WRITE) && waitreq_q);
		end
	end

	always_comb begin
		rdata_d = 8'h00;
		case (idx)
			IDX_CTRL1: rdata_d = ctrl1_q;
			IDX_CTRL2: rdata_d = ctrl2_q;
			IDX_BITCNT0: rdata_d = bit_hold_q[7:0];
			IDX_BITCNT1: rdata_d = bit_hold_q[15:8];
			IDX_BITCNT2: rdata_d = bit_hold_q[23:16];
			IDX_BITCNT3: rdata_d = bit_hold_q[31:24];
			IDX_ERRCNT0: rdata_d = err_hold_q[7:0];
			IDX_ERRCNT1: rdata_d = err_hold_q[15:8];
			IDX_ERRCNT2: rdata_d = err_hold_q[23:16];
			IDX_STATUS: rdata_d = {1'b0, status_q};
			IDX_MASK: rdata_d = {1'b0, mask_q};
			default: begin
				if (idx >= IDX_PATTERN0 && idx <= IDX_PATTERN3) begin
					rdata_d = pattern_q[{idx[1:0] - 2'h1, 3'h0} +: 8];
				end
			end
		endcase
	end

	// read data captured one edge ahead, so it stands while waitrequest is low
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			rdata_q <= REG_RESET;
		end else if (I_AVS_READ && waitreq_q) begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_pattern
			always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
				if (I_SYS_RST) begin
					pattern_q[8*k +: 8] <= REG_RESET;
				end else if (wr_lane0 && idx == IDX_PATTERN0 + 16'(k)) begin
					pattern_q[8*k +: 8] <= I_AVS_WRITEDATA[7:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctrl1_q <= REG_RESET;
			ctrl2_q <= REG_RESET;
			mask_q <= REG_RESET[ST_W-1:0];
		end else if (wr_lane0) begin
			if (idx == IDX_CTRL1) begin
				ctrl1_q <= I_AVS_WRITEDATA[7:0];
			end
			if (idx == IDX_CTRL2) begin
				ctrl2_q <= I_AVS_WRITEDATA[7:0];
			end
			if (idx == IDX_MASK) begin
				mask_q <= I_AVS_WRITEDATA[ST_W-1:0];
			end
		end
	end

	// edge detection: a held bit acts once, it must be cleared and set again
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctrl1_prev_q <= REG_RESET;
			ctrl2_prev_q <= REG_RESET;
		end else begin
			ctrl1_prev_q <= ctrl1_q;
			ctrl2_prev_q <= ctrl2_q;
		end
	end

	assign realign_rise = ctrl1_q[C1_REALIGN] && !ctrl1_prev_q[C1_REALIGN];
	assign latch_rise = ctrl1_q[C1_LATCH] && !ctrl1_prev_q[C1_LATCH];
	assign load_rise = ctrl1_q[C1_LOAD] && !ctrl1_prev_q[C1_LOAD];
	assign single_rise = ctrl2_q[C2_SINGLE] && !ctrl2_prev_q[C2_SINGLE];
	assign kind = kind_type'(ctrl1_q[C1_KIND_LSB +: 3]);

	////////////////////////////////////////////////////////////////////////////
	// transmit generator
	bert_pattern_engine #(
		.RESET_HISTORY(TX_SEED_RESET)
	) u_tx_engine (
		.i_clock(I_CLOCK),
		.i_sys_rst(I_SYS_RST),
		.i_step(I_TX_BIT_STROBE),
		.i_kind(kind),
		.i_len_code(ctrl2_q[C2_LEN_LSB +: 4]),
		.i_seed_load(load_rise),
		.i_seed(kind == KIND_PRBS7 || kind == KIND_PRBS11 || kind == KIND_PRBS15 || kind == KIND_QRSS ||
			kind == KIND_PRBS9 ? TX_SEED_RESET : pattern_q),
		.i_follow(1'b0),
		.i_in_bit(1'b0),
		.o_expected(tx_expected)
	);

	bert_error_inject u_inject (
		.i_clock(I_CLOCK),
		.i_sys_rst(I_SYS_RST),
		.i_step(I_TX_BIT_STROBE),
		.i_rate(ctrl2_q[C2_RATE_LSB +: 3]),
		.i_single_req(single_rise),
		.o_inject(tx_inject)
	);

	// the framer takes O_TX_DATA on its strobe; the next bit is then presented
	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			tx_q <= 1'b0;
		end else if (I_TX_BIT_STROBE) begin
			tx_q <= tx_expected ^ tx_inject ^ ctrl1_q[C1_TX_INV];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive checker
	assign rx_bit = I_RX_DATA ^ ctrl1_q[C1_RX_INV];
	assign mismatch = rx_bit != rx_expected;
	assign err_pulse = I_RX_BIT_STROBE && chk_q == CHK_LOCKED && mismatch;

	bert_pattern_engine #(
		.RESET_HISTORY(RX_SEED_RESET)
	) u_rx_engine (
		.i_clock(I_CLOCK),
		.i_sys_rst(I_SYS_RST),
		.i_step(I_RX_BIT_STROBE),
		.i_kind(kind),
		.i_len_code(ctrl2_q[C2_LEN_LSB +: 4]),
		.i_seed_load(1'b0),
		.i_seed(RX_SEED_RESET),
		.i_follow(chk_q == CHK_SEARCH),
		.i_in_bit(rx_bit),
		.o_expected(rx_expected)
	);

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			chk_q <= CHK_SEARCH;
			match_cnt_q <= 6'h00;
		end else if (realign_rise) begin
			chk_q <= CHK_SEARCH;
			match_cnt_q <= 6'h00;
		end else if (I_RX_BIT_STROBE) begin
			case (chk_q)
				CHK_SEARCH: begin
					match_cnt_q <= mismatch ? 6'h00 : match_cnt_q + 6'h01;
					if (!mismatch && match_cnt_q == LOCK_MATCH_LAST) begin
						chk_q <= CHK_LOCKED;
					end
				end
				CHK_LOCKED: begin
					match_cnt_q <= 6'h00;
					// too many errors in one window means the pattern slipped
					if (mismatch && window_err_q == LOSS_ERRORS - 3'h1) begin
						chk_q <= CHK_SEARCH;
					end
				end
				default: chk_q <= CHK_SEARCH;
			endcase
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			window_q <= 6'h00;
			window_err_q <= 3'h0;
		end else if (chk_q == CHK_SEARCH) begin
			window_q <= 6'h00;
			window_err_q <= 3'h0;
		end else if (I_RX_BIT_STROBE) begin
			window_q <= window_q + 6'h01;
			if (window_q == LOSS_WINDOW_LAST) begin
				window_err_q <= {2'h0, mismatch};
			end else begin
				window_err_q <= window_err_q + {2'h0, mismatch};
			end
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ones_run_q <= 6'h00;
			zeros_run_q <= 6'h00;
		end else if (I_RX_BIT_STROBE) begin
			ones_run_q <= !rx_bit ? 6'h00 : (ones_live ? RUN_FULL : ones_run_q + 6'h01);
			zeros_run_q <= rx_bit ? 6'h00 : (zeros_live ? RUN_FULL : zeros_run_q + 6'h01);
		end
	end

	assign ones_live = ones_run_q == RUN_FULL;
	assign zeros_live = zeros_run_q == RUN_FULL;

	////////////////////////////////////////////////////////////////////////////
	// counters and count latch
	assign bit_inc = I_RX_BIT_STROBE && chk_q == CHK_LOCKED;

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			bit_counter_q <= '0;
			error_counter_q <= '0;
			bit_hold_q <= '0;
			err_hold_q <= '0;
		end else if (latch_rise) begin
			bit_hold_q <= bit_counter_q;
			err_hold_q <= error_counter_q;
			bit_counter_q <= BIT_CNT_W'(bit_inc);
			error_counter_q <= ERR_CNT_W'(err_pulse);
		end else begin
			bit_counter_q <= bit_counter_q + BIT_CNT_W'(bit_inc);
			error_counter_q <= error_counter_q + ERR_CNT_W'(err_pulse);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latched status, cleared by reading; a set in the clearing cycle wins
	assign cond_live = {ones_live, zeros_live, chk_q == CHK_SEARCH, chk_q == CHK_LOCKED};

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cond_prev_q <= 4'h2;
		end else begin
			cond_prev_q <= cond_live;
		end
	end

	always_comb begin
		status_set = '0;
		status_set[ST_BIT_ERR] = err_pulse;
		status_set[ST_BIT_OVF] = bit_inc && !latch_rise && &bit_counter_q;
		status_set[ST_ERR_OVF] = err_pulse && !latch_rise && &error_counter_q;
		status_set[ST_ONES] = cond_live[3] != cond_prev_q[3];
		status_set[ST_ZEROS] = cond_live[2] != cond_prev_q[2];
		status_set[ST_LOST] = cond_live[1] != cond_prev_q[1];
		status_set[ST_LOCKED] = cond_live[0] != cond_prev_q[0];
	end

	// only bits the host actually saw are cleared
	assign status_clr = (rd_acc && idx == IDX_STATUS) ? rdata_q[ST_W-1:0] : '0;

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~status_clr) | status_set;
		end
	end

	always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	assign O_AVS_READDATA = {24'h000000, rdata_q};
	assign O_AVS_WAITREQUEST = waitreq_q;
	assign O_TX_DATA = tx_q;
	assign O_IRQ = irq_q;
endmodule

// ===== tb/bert_framer_model.sv
/*
 Framer side model: alternating tx and rx bit strobes, rx fed by a
 loopback of tx data or by a forced level.
 Assumes it shares the tester's clock and reset.
*/
module bert_framer_model (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_tx_data,
	input wire logic [1:0] i_mode,
	output logic o_tx_strobe,
	output logic o_rx_strobe,
	output logic o_rx_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic phase_q;
	logic bit_v;
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clock or posedge i_sys_rst) begin
		if (i_sys_rst) phase_q <= 1'b0;
		else phase_q <= ~phase_q;
	end
	assign o_tx_strobe = ~i_sys_rst & ~phase_q;
	assign o_rx_strobe = ~i_sys_rst & phase_q;
	// mode 1 forces ones, 2 zeros, 0 loops tx back
	assign bit_v = (i_mode == 2'h1) | ((i_mode == 2'h0) & i_tx_data);
	// off-strobe the line shows the inverse, so stale data never passes
	assign o_rx_data = o_rx_strobe ? bit_v : ~bit_v;
endmodule

// ===== tb/bert_tester_sva.sv
/*
 Checker for the tester's ports: bus handshake, read data, reset
 outputs, transmit hold and mask gating of the interrupt.
 Assumes binding to bert_tester, single clock domain.
*/
module bert_tester_sva (
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	input wire logic [bert_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	input wire logic I_TX_BIT_STROBE,
	input wire logic O_TX_DATA,
	input wire logic O_IRQ
);
	timeunit 1ns;
	timeprecision 100ps;
	import bert_pkg::*;
	default clocking dc @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);
	logic req;
	logic [15:0] idx;
	assign req = I_AVS_READ | I_AVS_WRITE;
	assign idx = I_AVS_ADDRESS[17:2];
	////////////////////////////////////////////////////////////////////////////
	chk_wait_answer: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("no answer one cycle after request");
	chk_wait_single: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	chk_wait_cause: assert property (!O_AVS_WAITREQUEST |-> $past(req))
		else $error("answer without request");
	chk_rdata_upper: assert property (O_AVS_READDATA[31:8] == 24'h000000)
		else $error("read data upper bits set");
	chk_unmapped_zero: assert property (I_AVS_READ && !O_AVS_WAITREQUEST && idx == 16'h1200 |-> O_AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_status_top: assert property (I_AVS_READ && !O_AVS_WAITREQUEST && (idx == IDX_STATUS || idx == IDX_MASK)
		|-> !O_AVS_READDATA[7]) else $error("status or mask bit 7 set");
	chk_mask_off: assert property (I_AVS_WRITE && !O_AVS_WAITREQUEST && idx == IDX_MASK && I_AVS_BYTEENABLE[0]
		&& I_AVS_WRITEDATA[6:0] == 7'h00 |=> ##1 !O_IRQ) else $error("irq with all masked");
	chk_reset_out: assert property ($fell(I_SYS_RST) |-> O_AVS_WAITREQUEST && !O_IRQ && !O_TX_DATA
		&& O_AVS_READDATA == 32'h0) else $error("outputs not at reset value");
	chk_tx_hold: assert property (!I_TX_BIT_STROBE |=> $stable(O_TX_DATA))
		else $error("tx data changed without strobe");
	////////////////////////////////////////////////////////////////////////////
	cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
	cover property ($rose(O_IRQ));
	cover property (I_AVS_READ && !O_AVS_WAITREQUEST && idx == IDX_STATUS && O_AVS_READDATA[0]);
endmodule

bind bert_tester bert_tester_sva i_sva (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
	.I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
	.I_TX_BIT_STROBE(I_TX_BIT_STROBE), .O_TX_DATA(O_TX_DATA), .O_IRQ(O_IRQ));

// ===== tb/bert_tester_tb.sv
/*
 Self-checking bench: registers, pattern kinds, lock, counts, error
 insertion, latched status and interrupt over Avalon-MM.
 Assumes the framer model loops tx back to rx on alternate cycles.
*/
module bert_tester_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bert_pkg::*;
	logic clk, rst, rd_req, wr_req, wait_req, irq, tx_stb, tx_data, rx_stb, rx_data;
	logic [ADDR_W-1:0] addr;
	logic [31:0] wdata, rdata, v, b;
	logic [23:0] e;
	logic [7:0] ctl;
	logic [1:0] mode;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	bert_tester i_dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_BYTEENABLE(4'h1),
		.I_AVS_READ(rd_req), .I_AVS_WRITE(wr_req), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(wait_req), .I_TX_BIT_STROBE(tx_stb), .O_TX_DATA(tx_data),
		.I_RX_BIT_STROBE(rx_stb), .I_RX_DATA(rx_data), .O_IRQ(irq));
	bert_framer_model i_far (.i_clock(clk), .i_sys_rst(rst), .i_tx_data(tx_data), .i_mode(mode),
		.o_tx_strobe(tx_stb), .o_rx_strobe(rx_stb), .o_rx_data(rx_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ceiling well above the roughly 3000 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d, output logic [7:0] q);
		addr <= {ix, 2'b00};
		wdata <= {24'h000000, d};
		wr_req <= w;
		rd_req <= !w;
		do @(posedge clk); while (wait_req !== 1'b0);
		q = rdata[7:0];
		wr_req <= 1'b0;
		rd_req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [15:0] ix, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, ix, d, q);
	endtask
	task automatic rd(input logic [15:0] ix, output logic [7:0] q);
		bus(1'b0, ix, 8'h00, q);
	endtask
	task automatic stc(input logic [7:0] m, input logic [7:0] x);
		logic [7:0] q;
		rd(IDX_STATUS, q);
		chk("status", q & m, x);
	endtask
	task automatic bits(input int n);
		repeat (2 * n) @(posedge clk);
	endtask
	// 32 transmitted bits, bit 0 first
	task automatic cap;
		for (int i = 0; i < 32; i++) begin
			do @(posedge clk); while (tx_stb !== 1'b1);
			@(posedge clk);
			v[i] = tx_data;
		end
	endtask
	task automatic latch;
		logic [7:0] q;
		wr(IDX_CTRL1, ctl);
		wr(IDX_CTRL1, ctl | 8'h02);
		for (int i = 0; i < 7; i++) begin
			rd(IDX_BITCNT0 + 16'(i), q);
			if (i < 4) b[8*i +: 8] = q;
			else e[8*(i-4) +: 8] = q;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] q;
		for (int i = 0; i < 15; i++) begin
			rd(IDX_PATTERN0 + 16'(i), q);
			chk("reset value", q, REG_RESET);
		end
		$display("done reset");
	endtask
	task automatic t_regs;
		logic [7:0] q;
		wr(IDX_MASK, 8'h7F);
		rd(IDX_MASK, q);
		chk("mask", q, 8'h7F);
		wr(IDX_MASK, 8'h00);
		wr(IDX_BITCNT0, 8'h55);
		rd(IDX_BITCNT0, q);
		chk("count read-only", q, 8'h00);
		wr(16'h1200, 8'hA5);
		rd(16'h1200, q);
		chk("unmapped", q, 8'h00);
		wr(IDX_CTRL2, 8'h0F);
		rd(IDX_CTRL2, q);
		chk("ctrl2", q, 8'h0F);
		wr(IDX_CTRL2, 8'h00);
		$display("done regs");
	endtask
	task automatic t_invert;
		wr(IDX_CTRL1, 8'h50);
		wr(IDX_CTRL1, 8'hD0);
		bits(40);
		cap();
		chk("tx inverted", v, 32'hFFFFFFFF);
		wr(IDX_CTRL1, 8'h10);
		bits(4);
		cap();
		chk("tx plain", v, 32'h00000000);
		$display("done invert");
	endtask
	// six-bit pattern in an 18-bit frame
	task automatic t_repeat;
		wr(IDX_PATTERN0, 8'hC7);
		wr(IDX_PATTERN0 + 16'h1, 8'h71);
		wr(IDX_CTRL2, 8'h01);
		wr(IDX_CTRL1, 8'h90);
		ctl = 8'h10;
		wr(IDX_CTRL1, ctl);
		bits(40);
		cap();
		chk("tx period", v[31:6], v[25:0]);
		chk("tx ones", $countones(v[5:0]), 3);
		$display("done repeat");
	endtask
	task automatic t_kinds;
		logic [7:0] q;
		for (int k = 0; k < 8; k++) begin
			rd(IDX_STATUS, q);
			ctl = 8'(k) << 2;
			wr(IDX_CTRL1, ctl);
			ctl = ctl | 8'h01;
			wr(IDX_CTRL1, ctl);
			bits(80);
			stc(8'h03, 8'h03);
		end
		rd(IDX_STATUS, q);
		wr(IDX_CTRL2, 8'h0F);
		bits(40);
		stc(8'h02, 8'h00);
		wr(IDX_CTRL2, 8'h00);
		$display("done kinds");
	endtask
	task automatic t_irq;
		logic [7:0] q;
		rd(IDX_STATUS, q);
		wr(IDX_MASK, 8'h02);
		wr(IDX_CTRL1, ctl & 8'hFE);
		wr(IDX_CTRL1, ctl);
		bits(4);
		chk("irq set", irq, 1'b1);
		bits(60);
		chk("irq held", irq, 1'b1);
		rd(IDX_STATUS, q);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 1'b0);
		wr(IDX_MASK, 8'h00);
		$display("done irq");
	endtask
	task automatic t_counts;
		latch();
		bits(20);
		latch();
		chk("errors", e, 24'h000000);
		chk("bit count range", b >= 28 && b <= 38, 1'b1);
		chk("bit count high", b[31:8], 24'h000000);
		$display("done counts");
	endtask
	task automatic t_single;
		logic [7:0] q;
		rd(IDX_STATUS, q);
		latch();
		wr(IDX_CTRL2, 8'h10);
		bits(40);
		latch();
		chk("error seen", e != 24'h0, 1'b1);
		stc(8'h40, 8'h40);
		bits(40);
		latch();
		chk("no second error", e, 24'h000000);
		wr(IDX_CTRL2, 8'h00);
		$display("done single");
	endtask
	task automatic t_rate;
		logic [7:0] q;
		rd(IDX_STATUS, q);
		wr(IDX_CTRL2, 8'h20);
		// loss needs six errors in one 64-bit window, which may start up to 63 bits late
		bits(160);
		stc(8'h42, 8'h42);
		wr(IDX_CTRL2, 8'h00);
		$display("done rate");
	endtask
	task automatic t_levels;
		logic [7:0] q;
		logic [7:0] m;
		for (int i = 1; i < 3; i++) begin
			m = (i == 1) ? 8'h08 : 8'h04;
			rd(IDX_STATUS, q);
			mode <= 2'(i);
			bits(40);
			stc(m, m);
			rd(IDX_STATUS, q);
			mode <= 2'h0;
			bits(10);
			stc(m, m);
		end
		$display("done levels");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		rd_req = 1'b0;
		wr_req = 1'b0;
		addr = '0;
		wdata = 32'h00000000;
		mode = 2'h0;
		ctl = 8'h00;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_regs();
		t_invert();
		t_repeat();
		t_kinds();
		t_irq();
		t_counts();
		t_single();
		t_rate();
		t_levels();
		summarize();
	end
endmodule
